// ---- verilog/digipot_serial_wiper_control.sv ----
// command decoder and wiper register of the digital potentiometer
`timescale 1ns/100ps
`include "pot_defines.svh"
module digipot_serial_wiper_control
  import pot_pkg::*;
#(
  parameter int SAVE_CYCLES = `SAVE_TIME_MS * `CLK_FREQ_KHZ
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic SCLK_I,
  input wire logic CS_B_I,
  input wire logic SERIAL_IN_PIN_I,
  input wire logic PRESET_RELOAD_PIN_B_I,
  output logic SERIAL_OUT_PIN_O,
  output logic SERIAL_OUT_PIN_OE_O,
  output logic RDY_O,
  output logic RDY_OE_O,
  output logic [`WIPER_W-1:0] WIPER_O
);

  store_if st ();

  state_t state;
  state_t next_state;
  instr_t last_instr;
  instr_t word_instr;
  instr_t eff_instr;

  logic [`WORD_W-1:0] word;
  logic word_tgl;
  logic lock;
  logic rb_mode;
  logic [`WORD_W-1:0] rb_word;

  logic [1:0] cs_sync;
  logic cs_d;
  logic [1:0] tgl_sync;
  logic tgl_seen;
  logic [1:0] pr_sync;
  logic pr_d;

  logic cs_rise;
  logic new_word;
  logic exec;
  logic pr_rise;
  logic ready;
  logic wr;
  logic [`NV_ADDR_W-1:0] waddr;
  logic [`NV_W-1:0] wdata;
  logic [`WIPER_W-1:0] wiper_scratch_register;
  logic [`WIPER_W-1:0] next_wiper;
  logic [`WIPER_W-1:0] nv_wiper;
  logic [`WIPER_W-1:0] data_wiper;

  if (SAVE_CYCLES < 1 || SAVE_CYCLES >= (1 << `SAVE_TIMER_W))
  begin : g_chk
    $error("digipot_serial_wiper_control: SAVE_CYCLES out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // step and shift codes that keep repeating on empty strobes
  function automatic logic repeats(input instr_t i);
    unique case (i)
      I_SHR_A, I_SHR_B, I_DEC_A, I_DEC_B,
      I_SHL_A, I_SHL_B, I_INC_A, I_INC_B:
        repeats = 1'b1;
      NO_OPERATION_INSTRUCTION, I_RESTORE, I_SAVE_WIPER, I_SAVE_DATA,
      I_RESET_RESTORE, I_READ_NV, I_READ_WIPER, I_WRITE_WIPER:
        repeats = 1'b0;
    endcase
  endfunction : repeats

  // commands that start a timed save
  function automatic logic saves(input instr_t i);
    saves = (i == I_SAVE_WIPER) || (i == I_SAVE_DATA);
  endfunction : saves

  ////////////////////////////////////////////////////////////////////////
  // link side

  serial_link #(
    .WORD_W(`WORD_W)
  ) u_link (
    .sclk_i(SCLK_I),
    .rst_b_i(RST_B_I),
    .cs_b_i(CS_B_I),
    .sdi_i(SERIAL_IN_PIN_I),
    .lock_i(lock),
    .rb_mode_i(rb_mode),
    .rb_word_i(rb_word),
    .word_o(word),
    .word_tgl_o(word_tgl),
    .sdo_o(SERIAL_OUT_PIN_O),
    .sdo_oe_o(SERIAL_OUT_PIN_OE_O)
  );

  ////////////////////////////////////////////////////////////////////////
  // storage

  nonvolatile_store #(
    .DEPTH(`NV_DEPTH),
    .SAVE_CYCLES(SAVE_CYCLES)
  ) u_store (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .st(st.mem)
  );

  assign st.wr = wr;
  assign st.waddr = waddr;
  assign st.wdata = wdata;
  assign st.raddr = word[`ADDR_HI:`ADDR_LO];
  assign nv_wiper = st.wiper_nv[`WIPER_HI:0];

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for pins and the word toggle

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      cs_sync <= 2'b11;
      cs_d <= 1'b1;
    end
    else
    begin
      cs_sync <= {cs_sync[0], CS_B_I};
      cs_d <= cs_sync[1];
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
      tgl_sync <= 2'b00;
    else
      tgl_sync <= {tgl_sync[0], word_tgl};
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      pr_sync <= 2'b11;
      pr_d <= 1'b1;
    end
    else
    begin
      pr_sync <= {pr_sync[0], PRESET_RELOAD_PIN_B_I};
      pr_d <= pr_sync[1];
    end
  end

  assign cs_rise = cs_sync[1] && !cs_d;
  assign pr_rise = pr_sync[1] && !pr_d;
  assign new_word = tgl_sync[1] != tgl_seen;

  ////////////////////////////////////////////////////////////////////////
  // decode

  assign word_instr = instr_t'(word[`CMD_HI:`CMD_LO]);
  assign exec = (state == S_IDLE) && cs_rise;
  assign data_wiper = word[`WIPER_HI:`DATA_LO];

  always_comb
  begin
    if (new_word)
      eff_instr = word_instr;
    else if (repeats(last_instr))
      eff_instr = last_instr;
    else
      eff_instr = NO_OPERATION_INSTRUCTION;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      tgl_seen <= 1'b0;
      last_instr <= NO_OPERATION_INSTRUCTION;
    end
    else if (exec)
    begin
      tgl_seen <= tgl_sync[1];
      if (new_word)
        last_instr <= word_instr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wiper arithmetic, all sixteen codes

  always_comb
  begin
    next_wiper = wiper_scratch_register;
    unique case (eff_instr)
      I_RESTORE, I_RESET_RESTORE:
        next_wiper = nv_wiper;
      I_WRITE_WIPER:
        next_wiper = data_wiper;
      I_SHR_A, I_SHR_B:
        next_wiper = wiper_scratch_register >> 1;
      I_SHL_A, I_SHL_B:
      begin
        if (wiper_scratch_register[`WIPER_HI])
          next_wiper = `WIPER_MAX;
        else
          next_wiper = wiper_scratch_register << 1;
      end
      I_DEC_A, I_DEC_B:
      begin
        if (wiper_scratch_register != `WIPER_MIN)
          next_wiper = wiper_scratch_register - 1'b1;
      end
      I_INC_A, I_INC_B:
      begin
        if (wiper_scratch_register != `WIPER_MAX)
          next_wiper = wiper_scratch_register + 1'b1;
      end
      NO_OPERATION_INSTRUCTION, I_SAVE_WIPER, I_SAVE_DATA,
      I_READ_NV, I_READ_WIPER:
        next_wiper = wiper_scratch_register;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // wiper register, preset pin has priority

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
      wiper_scratch_register <= `WIPER_MID;
    else if (!pr_sync[1])
      wiper_scratch_register <= `WIPER_MID;
    else if (pr_rise)
      wiper_scratch_register <= nv_wiper;
    else if (state == S_BOOT)
      wiper_scratch_register <= nv_wiper;
    else if (exec)
      wiper_scratch_register <= next_wiper;
  end

  // tap code drives the resistor directly, zero at B, ones at A
  assign WIPER_O = wiper_scratch_register;

  ////////////////////////////////////////////////////////////////////////
  // save requests

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      wr <= 1'b0;
      waddr <= `NV_WIPER_ADDR;
      wdata <= `NV_RESET_DATA;
    end
    else
    begin
      wr <= exec && saves(eff_instr);
      if (exec && eff_instr == I_SAVE_WIPER)
      begin
        waddr <= `NV_WIPER_ADDR;
        wdata <= {`WIPER_PAD, wiper_scratch_register};
      end
      else if (exec && eff_instr == I_SAVE_DATA)
      begin
        waddr <= word[`ADDR_HI:`ADDR_LO];
        wdata <= word[`DATA_HI:`DATA_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read-back word for the next frame

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      rb_mode <= 1'b0;
      rb_word <= '0;
    end
    else if (exec)
    begin
      rb_mode <= (eff_instr == I_READ_NV) || (eff_instr == I_READ_WIPER);
      if (eff_instr == I_READ_NV)
        rb_word <= {word[`CMD_HI:`ADDR_LO], st.rdata};
      else if (eff_instr == I_READ_WIPER)
        rb_word <= {word[`CMD_HI:`ADDR_LO], `WIPER_PAD,
          wiper_scratch_register};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: boot load, idle, save lock

  always_comb
  begin
    next_state = state;
    unique case (state)
      S_BOOT:
        next_state = S_IDLE;
      S_IDLE:
      begin
        if (exec && saves(eff_instr))
          next_state = S_SAVE;
      end
      S_SAVE:
      begin
        if (!wr && !st.busy)
          next_state = S_IDLE;
      end
      default:
        next_state = S_BOOT;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
      state <= S_BOOT;
    else
      state <= next_state;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      lock <= 1'b0;
      ready <= 1'b0;
    end
    else
    begin
      lock <= next_state == S_SAVE;
      ready <= next_state == S_IDLE;
    end
  end

  // open drain ready, pulled low while busy
  assign RDY_O = ready;
  assign RDY_OE_O = !ready;

endmodule : digipot_serial_wiper_control

// ---- inc/pot_defines.svh ----
// field positions, codes and timing constants of the wiper controller
`ifndef POT_DEFINES_SVH
`define POT_DEFINES_SVH

`define WORD_W 24
`define CMD_HI 23
`define CMD_LO 20
`define ADDR_HI 19
`define ADDR_LO 16
`define DATA_HI 15
`define DATA_LO 0
`define WIPER_HI 9
`define WIPER_W 10
`define NV_W 16
`define NV_DEPTH 16
`define NV_ADDR_W 4
`define NV_WIPER_ADDR 4'h0
`define WIPER_MID 10'h200
`define WIPER_MAX 10'h3FF
`define WIPER_MIN 10'h000
`define WIPER_PAD 6'h00
`define NV_RESET_DATA 16'h0000
`define SAVE_TIME_MS 25
`define CLK_FREQ_KHZ 125000
`define SAVE_TIMER_W 22
`define BIT_CNT_W 5

`endif

// ---- inc/pot_pkg.sv ----
// types shared by the wiper controller modules
package pot_pkg;

  typedef enum logic [3:0] {
    NO_OPERATION_INSTRUCTION = 4'h0,
    I_RESTORE = 4'h1,
    I_SAVE_WIPER = 4'h2,
    I_SAVE_DATA = 4'h3,
    I_SHR_A = 4'h4,
    I_SHR_B = 4'h5,
    I_DEC_A = 4'h6,
    I_DEC_B = 4'h7,
    I_RESET_RESTORE = 4'h8,
    I_READ_NV = 4'h9,
    I_READ_WIPER = 4'hA,
    I_WRITE_WIPER = 4'hB,
    I_SHL_A = 4'hC,
    I_SHL_B = 4'hD,
    I_INC_A = 4'hE,
    I_INC_B = 4'hF
  } instr_t;

  typedef enum logic [2:0] {
    S_BOOT = 3'h1,
    S_IDLE = 3'h2,
    S_SAVE = 3'h4
  } state_t;

endpackage : pot_pkg

// ---- inc/store_if.sv ----
// carrier between the controller and its nonvolatile store
`timescale 1ns/100ps
`include "pot_defines.svh"
interface store_if;
  logic wr;
  logic [`NV_ADDR_W-1:0] waddr;
  logic [`NV_W-1:0] wdata;
  logic [`NV_ADDR_W-1:0] raddr;
  logic [`NV_W-1:0] rdata;
  logic [`NV_W-1:0] wiper_nv;
  logic busy;
  modport ctrl (output wr, waddr, wdata, raddr,
    input rdata, wiper_nv, busy);
  modport mem (input wr, waddr, wdata, raddr,
    output rdata, wiper_nv, busy);
endinterface : store_if

// ---- verilog/serial_link.sv ----
// serial shift register on the link clock
`timescale 1ns/100ps
`include "pot_defines.svh"
module serial_link #(
  parameter int WORD_W = `WORD_W
) (
  input wire logic sclk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic sdi_i,
  input wire logic lock_i,
  input wire logic rb_mode_i,
  input wire logic [WORD_W-1:0] rb_word_i,
  output logic [WORD_W-1:0] word_o,
  output logic word_tgl_o,
  output logic sdo_o,
  output logic sdo_oe_o
);
  localparam logic [`BIT_CNT_W-1:0] LAST = `BIT_CNT_W'(WORD_W - 1);

  logic [1:0] rst_sync;
  logic [1:0] lock_sync;
  logic [`BIT_CNT_W-1:0] cnt;
  logic shift_en;
  logic out_bit;

  if (WORD_W < 2 || WORD_W > 32)
  begin : g_chk
    $error("serial_link: WORD_W out of range");
  end

  //////////////////////////////////////////////////////////////////////
  // reset and lock synchronisers
  always_ff @(posedge sclk_i)
  begin
    rst_sync <= {rst_sync[0], rst_b_i};
  end

  always_ff @(posedge sclk_i)
  begin
    if (!rst_sync[1])
      lock_sync <= 2'b00;
    else
      lock_sync <= {lock_sync[0], lock_i};
  end

  assign shift_en = !cs_b_i && !lock_sync[1];

  //////////////////////////////////////////////////////////////////////
  // shift msb first, one bit per rising edge
  always_ff @(posedge sclk_i)
  begin
    if (!rst_sync[1])
      word_o <= '0;
    else if (shift_en)
      word_o <= {word_o[WORD_W-2:0], sdi_i};
  end

  always_ff @(posedge sclk_i)
  begin
    if (!rst_sync[1])
    begin
      cnt <= '0;
      word_tgl_o <= 1'b0;
    end
    else if (shift_en)
    begin
      if (cnt == LAST)
      begin
        cnt <= '0;
        word_tgl_o <= !word_tgl_o;
      end
      else
        cnt <= cnt + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // open drain output, previous word or read-back word
  assign out_bit = rb_mode_i ? rb_word_i[LAST - cnt] : word_o[WORD_W-1];
  assign sdo_o = out_bit;
  assign sdo_oe_o = !cs_b_i && !out_bit;

endmodule : serial_link

// ---- verilog/nonvolatile_store.sv ----
// nonvolatile storage with timed save
`timescale 1ns/100ps
`include "pot_defines.svh"
module nonvolatile_store #(
  parameter int DEPTH = `NV_DEPTH,
  parameter int SAVE_CYCLES = `SAVE_TIME_MS * `CLK_FREQ_KHZ
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  store_if.mem st
);
  logic [`NV_W-1:0] mem [DEPTH];
  logic [DEPTH-1:0] written;
  logic [`SAVE_TIMER_W-1:0] timer;
  logic [`NV_W-1:0] rd_word;
  logic [`NV_W-1:0] nv_word;

  if (SAVE_CYCLES < 1 || SAVE_CYCLES >= (1 << `SAVE_TIMER_W)
      || DEPTH != `NV_DEPTH)
  begin : g_chk
    $error("nonvolatile_store: parameter out of range");
  end

  // unwritten locations return the factory value
  function automatic logic [`NV_W-1:0] rd(
    input logic [`NV_ADDR_W-1:0] a);
    if (written[a])
      rd = mem[a];
    else if (a == `NV_WIPER_ADDR)
      rd = {`WIPER_PAD, `WIPER_MID};
    else
      rd = `NV_RESET_DATA;
  endfunction : rd

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i)
  begin
    if (st.wr && !st.busy)
      mem[st.waddr] <= st.wdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      written <= '0;
    else if (st.wr && !st.busy)
      written[st.waddr] <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      st.busy <= 1'b0;
      timer <= '0;
    end
    else if (st.wr && !st.busy)
    begin
      st.busy <= 1'b1;
      timer <= `SAVE_TIMER_W'(SAVE_CYCLES - 1);
    end
    else if (st.busy)
    begin
      if (timer == '0)
        st.busy <= 1'b0;
      else
        timer <= timer - 1'b1;
    end
  end

  // a process, so new stored words and written flags wake the reads
  always_comb
  begin
    rd_word = rd(st.raddr);
    nv_word = rd(`NV_WIPER_ADDR);
  end

  assign st.rdata = rd_word;
  assign st.wiper_nv = nv_word;

endmodule : nonvolatile_store

// ---- tb/digipot_serial_wiper_control_checker.sv ----
// port-level assertions of the wiper controller
`timescale 1ns/100ps
`include "pot_defines.svh"
module digipot_serial_wiper_control_checker #(
  parameter int SAVE_CYCLES = 50
) (
  input wire logic CLK_I,
  input wire logic RST_B_I,
  input wire logic SCLK_I,
  input wire logic CS_B_I,
  input wire logic SERIAL_IN_PIN_I,
  input wire logic PRESET_RELOAD_PIN_B_I,
  input wire logic SERIAL_OUT_PIN_O,
  input wire logic SERIAL_OUT_PIN_OE_O,
  input wire logic RDY_O,
  input wire logic RDY_OE_O,
  input wire logic [`WIPER_W-1:0] WIPER_O
);
  int lo_cnt;
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  ////////////////////////////////////////////////////////////////////////////
  // busy length counter
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I || RDY_O)
      lo_cnt <= 0;
    else
      lo_cnt <= lo_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_boot_mid;
    $rose(RST_B_I) |-> WIPER_O == `WIPER_MID ##[1:4] RDY_O;
  endproperty
  property p_rdy_oe;
    RDY_OE_O == !RDY_O;
  endproperty
  property p_sdo_oe;
    SERIAL_OUT_PIN_OE_O |-> !CS_B_I && !SERIAL_OUT_PIN_O;
  endproperty
  property p_preset_mid;
    !PRESET_RELOAD_PIN_B_I [*5] |-> WIPER_O == `WIPER_MID;
  endproperty
  property p_frame_quiet;
    (!CS_B_I && PRESET_RELOAD_PIN_B_I) [*8] |=> $stable(WIPER_O);
  endproperty
  property p_save_min;
    $fell(RDY_O) |-> !RDY_O [*8];
  endproperty
  property p_save_max;
    lo_cnt <= SAVE_CYCLES + 4;
  endproperty
  property p_lock_quiet;
    (!RDY_O && PRESET_RELOAD_PIN_B_I) [*2] |=> $stable(WIPER_O);
  endproperty
  a_boot_mid: assert property (p_boot_mid)
    else $error("wiper not midscale after reset");
  a_rdy_oe: assert property (p_rdy_oe)
    else $error("ready enable not inverse of ready");
  a_sdo_oe: assert property (p_sdo_oe)
    else $error("serial out driven while deselected");
  a_preset_mid: assert property (p_preset_mid)
    else $error("preset low did not force midscale");
  a_frame_quiet: assert property (p_frame_quiet)
    else $error("wiper moved during a frame");
  a_save_min: assert property (p_save_min)
    else $error("ready returned too early");
  a_save_max: assert property (p_save_max)
    else $error("save busy too long");
  a_lock_quiet: assert property (p_lock_quiet)
    else $error("wiper moved while saving");
  c_save: cover property ($fell(RDY_O));
  c_strobe: cover property ($rose(CS_B_I));
  c_preset: cover property ($rose(PRESET_RELOAD_PIN_B_I));
endmodule : digipot_serial_wiper_control_checker

// ---- tb/spi_host_model.sv ----
// serial host that frames words and reads the output line
`timescale 1ns/100ps
module spi_host_model (
  output logic sclk_o,
  output logic cs_b_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  initial
  begin
    sclk_o = 1'b0;
    cs_b_o = 1'b1;
    sdi_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one whole frame, msb first, 6 ns link clock
  task automatic xfer(input logic [23:0] word, output logic [23:0] rx);
    cs_b_o = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdi_o = word[i];
      #3;
      rx[i] = sdo_i;
      sclk_o = 1'b1;
      #3;
      sclk_o = 1'b0;
    end
    #3;
    cs_b_o = 1'b1;
    sdi_o = ~word[0];
  endtask : xfer
  // select strobe with no clock edges
  task automatic strobe();
    cs_b_o = 1'b0;
    #24;
    cs_b_o = 1'b1;
  endtask : strobe
  // link clock edges while deselected, for reset
  task automatic pump();
    repeat (4)
    begin
      #3;
      sclk_o = 1'b1;
      #3;
      sclk_o = 1'b0;
    end
  endtask : pump
endmodule : spi_host_model

// ---- tb/digipot_serial_wiper_control_tb.sv ----
// self-checking bench of the wiper controller
`timescale 1ns/100ps
`include "pot_defines.svh"
module digipot_serial_wiper_control_tb;
  localparam int SAVE_CYC = 50;
  localparam logic [24:0] OPS [20] = '{25'h0B003FE, 25'h0E00000,
    25'h1000000, 25'h0B00001, 25'h0700000, 25'h1000000, 25'h0F00000,
    25'h0600000, 25'h0B00100, 25'h0C00000, 25'h0D00000, 25'h0500000,
    25'h0400000, 25'h1000000, 25'h0B00005, 25'h0000000, 25'h1000000,
    25'h0100000, 25'h0B00007, 25'h0800000};
  localparam logic [9:0] EXP [20] = '{10'h3FE, 10'h3FF, 10'h3FF, 10'h001,
    10'h000, 10'h000, 10'h001, 10'h000, 10'h100, 10'h200, 10'h3FF, 10'h1FF,
    10'h0FF, 10'h07F, 10'h005, 10'h005, 10'h005, 10'h100, 10'h007, 10'h100};
  logic clk, rst_b, preset_b, sclk, cs_b, serial_in_pin, sdo_wire;
  logic serial_out_pin, sdo_oe, rdy, rdy_oe;
  logic [9:0] wiper;
  logic [23:0] rx;
  int error_cnt, samples_checked;
  assign sdo_wire = sdo_oe ? 1'b0 : 1'b1;
  digipot_serial_wiper_control #(.SAVE_CYCLES(SAVE_CYC))
    u_digipot_serial_wiper_control (.CLK_I(clk), .RST_B_I(rst_b),
    .SCLK_I(sclk), .CS_B_I(cs_b), .SERIAL_IN_PIN_I(serial_in_pin),
    .PRESET_RELOAD_PIN_B_I(preset_b), .SERIAL_OUT_PIN_O(serial_out_pin),
    .SERIAL_OUT_PIN_OE_O(sdo_oe), .RDY_O(rdy), .RDY_OE_O(rdy_oe),
    .WIPER_O(wiper));
  spi_host_model u_spi_host_model (.sclk_o(sclk), .cs_b_o(cs_b),
    .sdi_o(serial_in_pin), .sdo_i(sdo_wire));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string name, logic [23:0] exp, logic [23:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic idle(int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic send(logic [23:0] word);
    u_spi_host_model.xfer(word, rx);
    idle(12);
  endtask : send
  task automatic wait_rdy();
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk("ready", 24'h1, {23'h0, rdy});
  endtask : wait_rdy
  task automatic t_boot();
    rst_b = 1'b0;
    fork
      u_spi_host_model.pump();
      idle(16);
    join
    rst_b = 1'b1;
    // link edges while deselected clear the link reset synchroniser
    fork
      u_spi_host_model.pump();
      idle(4);
    join
    chk("wiper", 24'h200, {14'h0, wiper});
    chk("ready", 24'h1, {23'h0, rdy});
    $display("t_boot done");
  endtask : t_boot
  task automatic t_save();
    send(24'hB00100);
    chk("wiper", 24'h100, {14'h0, wiper});
    send(24'h20FFFF);
    chk("echo", 24'hB00100, rx);
    chk("ready", 24'h0, {23'h0, rdy});
    send(24'hB003AA);
    chk("wiper", 24'h100, {14'h0, wiper});
    wait_rdy();
    send(24'hB003AA);
    chk("wiper", 24'h3AA, {14'h0, wiper});
    preset_b = 1'b0;
    idle(6);
    chk("wiper", 24'h200, {14'h0, wiper});
    preset_b = 1'b1;
    idle(8);
    chk("wiper", 24'h100, {14'h0, wiper});
    $display("t_save done");
  endtask : t_save
  task automatic t_ops();
    for (int i = 0; i < 20; i++)
    begin
      if (OPS[i][24])
      begin
        u_spi_host_model.strobe();
        idle(12);
      end
      else
        send(OPS[i][23:0]);
      chk("wiper", {14'h0, EXP[i]}, {14'h0, wiper});
    end
    $display("t_ops done");
  endtask : t_ops
  task automatic t_read();
    send(24'hA00000);
    send(24'h000000);
    chk("read wiper", 24'hA00100, rx);
    send(24'h900000);
    send(24'h000000);
    chk("read store", 24'h900100, rx);
    send(24'h310ABC);
    wait_rdy();
    send(24'h910000);
    send(24'h000000);
    chk("read data", 24'h910ABC, rx);
    send(24'h123456);
    chk("echo", 24'h000000, rx);
    $display("t_read done");
  endtask : t_read
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0;
    preset_b = 1'b1;
    error_cnt = 0;
    samples_checked = 0;
    @(negedge clk);
    t_boot();
    t_save();
    t_ops();
    t_read();
    t_boot();
    tally_and_finish();
  end
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : digipot_serial_wiper_control_tb
bind digipot_serial_wiper_control digipot_serial_wiper_control_checker
  #(.SAVE_CYCLES(SAVE_CYCLES)) u_digipot_serial_wiper_control_checker (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .SCLK_I(SCLK_I), .CS_B_I(CS_B_I),
  .SERIAL_IN_PIN_I(SERIAL_IN_PIN_I),
  .PRESET_RELOAD_PIN_B_I(PRESET_RELOAD_PIN_B_I),
  .SERIAL_OUT_PIN_O(SERIAL_OUT_PIN_O),
  .SERIAL_OUT_PIN_OE_O(SERIAL_OUT_PIN_OE_O), .RDY_O(RDY_O),
  .RDY_OE_O(RDY_OE_O), .WIPER_O(WIPER_O));
